// *** core/accel_mode_and_offset_control.sv ***
`timescale 1ns/1ps
// accelerometer mode control, register file and serial slave
module accel_mode_and_offset_control (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_CLK_EN,
  input  wire logic                 I_SCL,
  input  wire logic                 I_SDA,
  output logic                      O_SDA_OUT,
  output logic                      O_SDA_OE,
  input  wire accel_pkg::trim_set_t I_TRIM,
  input  wire logic                 I_TRIM_VALID,
  input  wire accel_pkg::axis_raw_t I_AXIS_RAW,
  input  wire logic                 I_SAMPLE_STB,
  input  wire logic                 I_FREEFALL_EV,
  input  wire logic                 I_ORIENT_EV,
  input  wire logic                 I_WAKE_EV,
  input  wire logic                 I_SLEEP_REQ,
  output logic                      O_AFE_EN,
  output logic                      O_CLK_RUN,
  output logic                      O_SELF_TEST,
  output logic [1:0]                O_OSR_MODE,
  output logic                      O_SLEEP,
  output logic                      O_EVENT_LINE_ONE,
  output logic                      O_EVENT_LINE_TWO
);
  import accel_pkg::*;

  typedef enum logic [5:0] {
    BUS_IDLE  = 6'b000001,
    BUS_ADDR  = 6'b000010,
    BUS_WRITE = 6'b000100,
    BUS_ACK   = 6'b001000,
    BUS_READ  = 6'b010000,
    BUS_RACK  = 6'b100000
  } bus_state_t;
  typedef enum logic [2:0] {
    MODE_STBY  = 3'b001,
    MODE_WAKE  = 3'b010,
    MODE_SLEEP = 3'b100
  } mode_state_t;

  bus_state_t  bus_q, bus_d;
  mode_state_t mode_q, mode_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  shift_q, shift_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        ptr_set_q, ptr_set_d;
  logic        rd_q, rd_d;
  logic        ack_on_q, ack_on_d;
  logic        oe_q, oe_d;
  logic        scl_q, sda_q;
  logic        scl_rise, scl_fall, start_c, stop_c;
  logic        load_rd, wr_stb, rd_stb;
  logic [7:0]  wr_data, rd_data;
  logic        run_q, run_d, fast_q, fast_d, stest_q, stest_d;
  logic [1:0]  osr_q, osr_d, range_q, range_d;
  logic [3:0]  ev_en_q, ev_en_d, ev_route_q, ev_route_d;
  logic [3:0]  flags_q, flags_d;
  logic [2:0][7:0] uoff_q, uoff_d;
  axis_code_t  out_q, out_d, cond;
  trim_set_t   trim_q, trim_d;
  logic        trim_ok_q, trim_ok_d;
  logic        line1_q, line1_d, line2_q, line2_d;
  logic        take;
  events_t     ev_in;

  // fast read steps over the low output bytes so only the upper halves are fetched
  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic fast);
    if (fast && p < REG_STATUS && !p[0]) begin
      return p + 8'h02;
    end else if (p == REG_LAST) begin
      return REG_OUT_XH;
    end
    return p + 8'h01;
  endfunction

  for (genvar a = 0; a < 3; a++) begin : g_axis
    axis_conditioner u_cond (
      .i_raw       (I_AXIS_RAW[a]),
      .i_trim      (trim_q[a]),
      .i_self_test (stest_q),
      .i_range     (range_q),
      .i_user_off  (uoff_q[a]),
      .o_code      (cond[a])
    );
  end

  assign scl_rise = !scl_q && I_SCL;
  assign scl_fall = scl_q && !I_SCL;
  assign start_c  = scl_q && I_SCL && sda_q && !I_SDA;
  assign stop_c   = scl_q && I_SCL && !sda_q && I_SDA;

  always_comb begin
    rd_data = 8'h00;
    for (int a = 0; a < 3; a++) begin
      if (ptr_q == REG_OUT_XH + 8'(2 * a)) rd_data = out_q[a][9:2];
      if (ptr_q == REG_OUT_XH + 8'(2 * a + 1)) rd_data = {out_q[a][1:0], 6'h00};
      if (ptr_q == REG_UOFF_X + 8'(a)) rd_data = uoff_q[a];
    end
    unique case (ptr_q)
      REG_STATUS:    rd_data = {4'h0, flags_q};
      REG_RUN_CTRL:  rd_data[FREAD_BIT:RUN_BIT] = {fast_q, run_q};
      REG_MEAS_CTRL: rd_data = {stest_q, 5'h00, osr_q};
      REG_RANGE:     rd_data = {6'h00, range_q};
      REG_EV_EN:     rd_data = {4'h0, ev_en_q};
      REG_EV_ROUTE:  rd_data = {4'h0, ev_route_q};
      REG_MODE:      rd_data = {6'h00, mode_q == MODE_SLEEP ? MODE_CODE_SLEEP :
                                mode_q == MODE_WAKE ? MODE_CODE_WAKE : MODE_CODE_STBY};
      default: ;
    endcase
  end

  // serial slave; it only ever drives the data line, the clock is the master's alone
  always_comb begin
    bus_d     = bus_q;
    bit_d     = bit_q;
    shift_d   = shift_q;
    ptr_d     = ptr_q;
    ptr_set_d = ptr_set_q;
    rd_d      = rd_q;
    ack_on_d  = ack_on_q;
    oe_d      = oe_q;
    load_rd   = 1'b0;
    wr_stb    = 1'b0;
    rd_stb    = 1'b0;
    wr_data   = {shift_q[6:0], I_SDA};
    if (start_c) begin
      bus_d    = BUS_ADDR;
      bit_d    = 4'h0;
      oe_d     = 1'b0;
      ack_on_d = 1'b0;
    end else if (stop_c) begin
      bus_d = BUS_IDLE;
      oe_d  = 1'b0;
    end else begin
      unique case (bus_q)
        BUS_IDLE: ;
        BUS_ADDR, BUS_WRITE: if (scl_rise) begin
          shift_d = wr_data;
          bit_d   = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            bus_d = BUS_ACK;
            if (bus_q == BUS_ADDR) begin
              rd_d      = I_SDA;
              ptr_set_d = 1'b0;
              if (shift_q[6:0] != DEV_ADDR) bus_d = BUS_IDLE;
            end else if (!ptr_set_q) begin
              ptr_d     = wr_data;
              ptr_set_d = 1'b1;
            end else begin
              wr_stb = 1'b1;
              ptr_d  = next_ptr(ptr_q, 1'b0);
            end
          end
        end
        BUS_ACK: if (scl_fall) begin
          ack_on_d = !ack_on_q;
          oe_d     = !ack_on_q;
          bit_d    = 4'h0;
          if (ack_on_q) begin
            bus_d   = BUS_WRITE;
            load_rd = rd_q;
          end
        end
        BUS_READ: begin
          if (scl_rise) bit_d = bit_q + 4'h1;
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              oe_d  = 1'b0;
              bus_d = BUS_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = !shift_q[6];
            end
          end
        end
        BUS_RACK: begin
          if (scl_rise && I_SDA) begin
            bus_d = BUS_IDLE;
          end else if (scl_fall) begin
            load_rd = 1'b1;
          end
        end
      endcase
    end
    if (load_rd) begin
      shift_d = rd_data;
      oe_d    = !rd_data[7];
      bit_d   = 4'h0;
      bus_d   = BUS_READ;
      rd_stb  = 1'b1;
      ptr_d   = next_ptr(ptr_q, fast_q);
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bus_q     <= BUS_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= REG_OUT_XH;
      ptr_set_q <= 1'b0;
      rd_q      <= 1'b0;
      ack_on_q  <= 1'b0;
      oe_q      <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else if (I_CLK_EN) begin
      bus_q     <= bus_d;
      bit_q     <= bit_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      ptr_set_q <= ptr_set_d;
      rd_q      <= rd_d;
      ack_on_q  <= ack_on_d;
      oe_q      <= oe_d;
      scl_q     <= I_SCL;
      sda_q     <= I_SDA;
    end
  end

  // register file, sample capture, events and operating mode
  assign ev_in = '{wake: I_WAKE_EV, orient: I_ORIENT_EV, freefall: I_FREEFALL_EV, drdy: 1'b0};
  assign take  = run_q && trim_ok_q && I_SAMPLE_STB;

  always_comb begin
    run_d      = run_q;
    fast_d     = fast_q;
    stest_d    = stest_q;
    osr_d      = osr_q;
    range_d    = range_q;
    ev_en_d    = ev_en_q;
    ev_route_d = ev_route_q;
    uoff_d     = uoff_q;
    out_d      = out_q;
    flags_d    = flags_q;
    trim_d     = trim_q;
    trim_ok_d  = trim_ok_q;
    if (!trim_ok_q && I_TRIM_VALID) begin
      trim_d    = I_TRIM;
      trim_ok_d = 1'b1;
    end
    if (wr_stb) begin
      for (int a = 0; a < 3; a++) begin
        if (ptr_q == REG_UOFF_X + 8'(a)) uoff_d[a] = wr_data;
      end
      unique case (ptr_q)
        REG_RUN_CTRL: begin
          run_d  = wr_data[RUN_BIT];
          fast_d = wr_data[FREAD_BIT];
        end
        REG_MEAS_CTRL: begin
          stest_d = wr_data[STEST_BIT];
          osr_d   = wr_data[OSR_LSB+1:OSR_LSB];
        end
        REG_RANGE:    if (wr_data[1:0] != RNG_BAD) range_d = wr_data[1:0];
        REG_EV_EN:    ev_en_d = wr_data[3:0];
        REG_EV_ROUTE: ev_route_d = wr_data[3:0];
        default: ;
      endcase
    end
    if (rd_stb && ptr_q == REG_STATUS) flags_d = flags_q & ~rd_data[3:0];
    if (run_d && !run_q) begin
      out_d   = '0;
      flags_d = FLAGS_RST;
    end
    // set after clear so an event in the clearing cycle survives; range never gates events
    if (run_q) flags_d = flags_d | ev_in;
    if (take) begin
      out_d            = cond;
      flags_d[EV_DRDY] = 1'b1;
    end
    mode_d = mode_q;
    unique case (mode_q)
      MODE_STBY:  if (run_d) mode_d = MODE_WAKE;
      MODE_WAKE:  if (!run_d) mode_d = MODE_STBY;
                  else if (I_SLEEP_REQ) mode_d = MODE_SLEEP;
      MODE_SLEEP: if (!run_d) mode_d = MODE_STBY;
                  else if (!I_SLEEP_REQ || I_WAKE_EV) mode_d = MODE_WAKE;
      default:    mode_d = MODE_STBY;
    endcase
    line1_d = |(flags_q & ev_en_q & ev_route_q);
    line2_d = |(flags_q & ev_en_q & ~ev_route_q);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      run_q      <= CTRL_RST[RUN_BIT];
      fast_q     <= CTRL_RST[FREAD_BIT];
      stest_q    <= CTRL_RST[STEST_BIT];
      osr_q      <= CTRL_RST[1:0];
      range_q    <= RNG_2G;
      ev_en_q    <= CTRL_RST[3:0];
      ev_route_q <= CTRL_RST[3:0];
      uoff_q     <= {3{UOFF_RST}};
      out_q      <= {3{OUT_RST}};
      flags_q    <= FLAGS_RST;
      trim_q     <= '0;
      trim_ok_q  <= 1'b0;
      mode_q     <= MODE_STBY;
      line1_q    <= 1'b0;
      line2_q    <= 1'b0;
    end else if (I_CLK_EN) begin
      run_q      <= run_d;
      fast_q     <= fast_d;
      stest_q    <= stest_d;
      osr_q      <= osr_d;
      range_q    <= range_d;
      ev_en_q    <= ev_en_d;
      ev_route_q <= ev_route_d;
      uoff_q     <= uoff_d;
      out_q      <= out_d;
      flags_q    <= flags_d;
      trim_q     <= trim_d;
      trim_ok_q  <= trim_ok_d;
      mode_q     <= mode_d;
      line1_q    <= line1_d;
      line2_q    <= line2_d;
    end
  end

  assign O_SDA_OUT        = 1'b0;
  assign O_SDA_OE         = oe_q;
  assign O_AFE_EN         = run_q;
  assign O_CLK_RUN        = run_q;
  assign O_SELF_TEST      = stest_q;
  assign O_OSR_MODE       = osr_q;
  assign O_SLEEP          = mode_q == MODE_SLEEP;
  assign O_EVENT_LINE_ONE = line1_q;
  assign O_EVENT_LINE_TWO = line2_q;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  sda_drive_edge_a: assert property ($changed(oe_q) |-> $past(scl_fall || start_c || stop_c))
    else $error("data line drive changed away from a clock fall");
  out_capture_a: assert property (I_CLK_EN && take |=> out_q == $past(cond))
    else $error("sample not captured into output data");
  standby_quiet_a: assert property (!run_q |-> !take && !O_AFE_EN && !O_CLK_RUN)
    else $error("measurement activity in standby");
  active_sample_a: assert property (I_CLK_EN && take |=> flags_q[EV_DRDY])
    else $error("active sample did not raise data ready");
  wake_clear_a: assert property (I_CLK_EN && run_d && !run_q |=> out_q == '0 && flags_q == '0)
    else $error("standby to active did not clear data and flags");
  mode_in_active_a: assert property (mode_q != MODE_STBY |-> run_q)
    else $error("sleep or wake outside active");
  line_route_a: assert property (I_CLK_EN |=>
      O_EVENT_LINE_ONE == $past(|(flags_q & ev_en_q & ev_route_q)))
    else $error("event line one does not follow routing");
  trim_first_a: assert property (!trim_ok_q |-> !flags_q[EV_DRDY])
    else $error("data ready before trim loaded");
  uoff_write_a: assert property (I_CLK_EN && wr_stb && ptr_q == REG_UOFF_X |=>
      uoff_q[0] == $past(wr_data))
    else $error("user offset write lost");

  cover property (bus_q == BUS_RACK && scl_rise && !I_SDA);
  cover property (I_CLK_EN && mode_q == MODE_WAKE ##1 mode_q == MODE_SLEEP);
  cover property (take && stest_q && range_q == RNG_8G);
  cover property ($rose(O_EVENT_LINE_TWO));
endmodule

// *** core/accel_pkg.sv ***
// shared constants, field positions and carrier types of the accelerometer control block
package accel_pkg;
  // serial slave address, arbitrary value
  localparam logic [6:0] DEV_ADDR      = 7'h1D;
  localparam logic [7:0] REG_OUT_XH    = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h06;
  localparam logic [7:0] REG_RUN_CTRL  = 8'h07;
  localparam logic [7:0] REG_MEAS_CTRL = 8'h08;
  localparam logic [7:0] REG_RANGE     = 8'h09;
  localparam logic [7:0] REG_EV_EN     = 8'h0A;
  localparam logic [7:0] REG_EV_ROUTE  = 8'h0B;
  localparam logic [7:0] REG_UOFF_X    = 8'h0C;
  localparam logic [7:0] REG_MODE      = 8'h0F;
  localparam logic [7:0] REG_LAST      = 8'h0F;
  localparam int         RUN_BIT       = 0;
  localparam int         FREAD_BIT     = 1;
  localparam int         STEST_BIT     = 7;
  localparam int         OSR_LSB       = 0;
  localparam int         EV_DRDY       = 0;
  localparam logic [1:0] RNG_2G        = 2'h0;
  localparam logic [1:0] RNG_4G        = 2'h1;
  localparam logic [1:0] RNG_8G        = 2'h2;
  localparam logic [1:0] RNG_BAD       = 2'h3;
  localparam logic [1:0] MODE_CODE_STBY  = 2'h0;
  localparam logic [1:0] MODE_CODE_WAKE  = 2'h1;
  localparam logic [1:0] MODE_CODE_SLEEP = 2'h2;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  UOFF_RST     = 8'h00;
  localparam logic [9:0]  OUT_RST      = 10'h000;
  localparam logic [3:0]  FLAGS_RST    = 4'h0;
  // test stimulus in raw units of 1/256 g, arbitrary plain value
  localparam logic signed [16:0] ST_STIM  = 17'sh00030;
  localparam int                 GAIN_SHIFT = 7;
  localparam logic signed [18:0] CODE_MAX = 19'sh001FF;
  localparam logic signed [18:0] CODE_MIN = -19'sh00200;
  localparam logic [9:0]         SAT_POS  = 10'h1FF;
  localparam logic [9:0]         SAT_NEG  = 10'h200;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] dev;
  } trim_t;
  typedef trim_t     [2:0]       trim_set_t;
  typedef logic      [2:0][15:0] axis_raw_t;
  typedef logic      [2:0][9:0]  axis_code_t;
  typedef struct packed {
    logic wake;
    logic orient;
    logic freefall;
    logic drdy;
  } events_t;
endpackage

// *** core/axis_conditioner.sv ***
`timescale 1ns/1ps
// one axis of the sample path: self-test, trim, range scaling, user offset, saturation
module axis_conditioner (
  input  wire logic [15:0]      i_raw,
  input  wire accel_pkg::trim_t i_trim,
  input  wire logic             i_self_test,
  input  wire logic [1:0]       i_range,
  input  wire logic [7:0]       i_user_off,
  output logic      [9:0]       o_code
);
  import accel_pkg::*;

  logic signed [16:0] stim_sum;
  logic signed [25:0] product;
  logic signed [18:0] trimmed;
  logic signed [18:0] scaled;
  logic signed [18:0] corrected;

  always_comb begin
    stim_sum = 17'($signed(i_raw)) + (i_self_test ? ST_STIM : 17'sh00000);
    // gain of 128 is unity; the zero-g deviation is removed after the gain
    product  = stim_sum * $signed({1'b0, i_trim.gain});
    trimmed  = 19'(product >>> GAIN_SHIFT) - 19'($signed(i_trim.dev));
    unique case (i_range)
      RNG_4G:  scaled = trimmed >>> 1;
      RNG_8G:  scaled = trimmed >>> 2;
      default: scaled = trimmed;
    endcase
    corrected = scaled + 19'($signed(i_user_off));
    if (corrected > CODE_MAX) begin
      o_code = SAT_POS;
    end else if (corrected < CODE_MIN) begin
      o_code = SAT_NEG;
    end else begin
      o_code = corrected[9:0];
    end
  end
endmodule

// *** dv/host_bus_master.sv ***
// host-side serial bus master model that talks to the accelerometer slave
`timescale 1ns/1ps
module host_bus_master #(
  parameter int Q = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_sda,
  output logic            o_scl,
  output logic            o_sda,
  output logic            o_res_stb,
  output logic [8:0]      o_res_val
);
  import accel_pkg::*;

  initial begin
    o_scl     = 1'b1;
    o_sda     = 1'b1;
    o_res_stb = 1'b0;
    o_res_val = 9'h000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // the master alone times every clock phase and never waits on the slave
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    tick(Q);
    o_scl = 1'b1;
    tick(Q);
    r = i_sda;
    tick(Q);
    o_scl = 1'b0;
    tick(Q);
  endtask

  // results go out as one-cycle pulses: bit 8 set marks an acknowledge bit
  task automatic report(input logic [8:0] v);
    o_res_val = v;
    o_res_stb = 1'b1;
    tick(1);
    o_res_stb = 1'b0;
  endtask

  task automatic start();
    o_sda = 1'b1;
    tick(Q);
    o_scl = 1'b1;
    tick(Q);
    o_sda = 1'b0;
    tick(Q);
    o_scl = 1'b0;
    tick(Q);
  endtask

  task automatic stop();
    o_sda = 1'b0;
    tick(Q);
    o_scl = 1'b1;
    tick(Q);
    o_sda = 1'b1;
    tick(Q);
  endtask

  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    report({1'b1, 7'h00, r});
  endtask

  task automatic recv(input logic last);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
    report({1'b0, d});
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] val);
    start();
    send({DEV_ADDR, 1'b0});
    send(ptr);
    send(val);
    stop();
  endtask

  task automatic read_regs(input logic [7:0] ptr, input int n);
    start();
    send({DEV_ADDR, 1'b0});
    send(ptr);
    start();
    send({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) recv(i == n - 1);
    stop();
  endtask

  task automatic probe(input logic [6:0] addr);
    start();
    send({addr, 1'b0});
    stop();
  endtask
endmodule

// *** dv/test_accel_mode_and_offset_control.sv ***
// self-checking bench for the accelerometer mode, offset and readout block
`timescale 1ns/1ps
module test_accel_mode_and_offset_control;
  import accel_pkg::*;
  logic       clk, rst_n, trim_valid, scl, m_sda, sda_out, sda_oe, sample_stb;
  logic       ff_ev, orient_ev, wake_ev, sleep_req, afe_en, clk_run, self_test, sleep;
  logic       line_one, line_two, res_stb, clk_en;
  logic [1:0] osr;
  logic [8:0] res_val, note;
  logic [7:0] uoff [3];
  logic [7:0] msb  [3];
  logic [8:0] notes[$];
  logic [7:0] pend[$];
  trim_set_t  trim;
  axis_raw_t  raw;
  wire        sda_wire;
  int         err_count, samples_checked;
  int         seed = 32'hC440B7E4;

  // open-drain wire with pull-up: low if either party pulls
  assign sda_wire = m_sda & (sda_oe ? sda_out : 1'b1);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  accel_mode_and_offset_control dut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en), .I_SCL(scl), .I_SDA(sda_wire),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_TRIM(trim), .I_TRIM_VALID(trim_valid),
    .I_AXIS_RAW(raw), .I_SAMPLE_STB(sample_stb), .I_FREEFALL_EV(ff_ev),
    .I_ORIENT_EV(orient_ev), .I_WAKE_EV(wake_ev), .I_SLEEP_REQ(sleep_req),
    .O_AFE_EN(afe_en), .O_CLK_RUN(clk_run), .O_SELF_TEST(self_test), .O_OSR_MODE(osr),
    .O_SLEEP(sleep), .O_EVENT_LINE_ONE(line_one), .O_EVENT_LINE_TWO(line_two));

  host_bus_master #(.Q(4)) host (
    .i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(m_sda),
    .o_res_stb(res_stb), .o_res_val(res_val));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fail(input string msg);
    $display("mismatch at %0t: %s", $time, msg);
    err_count++;
  endtask

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask

  task automatic compare_ack(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("acknowledge bit %b, expected %b", got, exp));
  endtask

  task automatic compare_pin(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s is %b, expected %b", what, got, exp));
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    repeat (3) notes.push_back(9'h100);
    host.write_reg(ptr, val);
  endtask

  // pending bytes queued by the caller follow the three acknowledge bits
  task automatic rd(input logic [7:0] ptr);
    int n;
    n = pend.size();
    repeat (3) notes.push_back(9'h100);
    while (pend.size() > 0) notes.push_back({1'b0, pend.pop_front()});
    host.read_regs(ptr, n);
  endtask

  function automatic logic [9:0] expect_code(input logic [15:0] r, input trim_t t,
                                             input logic st, input int sh,
                                             input logic [7:0] off);
    int v;
    v = (int'($signed(r)) + (st ? int'(ST_STIM) : 0)) * int'(t.gain);
    v = (v >>> 7) - int'($signed(t.dev));
    v = (v >>> sh) + int'($signed(off));
    if (v > 511) v = 511;
    if (v < -512) v = -512;
    return v[9:0];
  endfunction

  task automatic sample_check(input logic st, input int sh);
    logic [9:0] c;
    for (int a = 0; a < 3; a++) raw[a] = 16'($random(seed) % 700);
    sample_stb = 1'b1;
    step(1);
    sample_stb = 1'b0;
    for (int a = 0; a < 3; a++) begin
      c = expect_code(raw[a], trim[a], st, sh, uoff[a]);
      pend.push_back(c[9:2]);
      pend.push_back({c[1:0], 6'h00});
      msb[a] = c[9:2];
    end
    rd(REG_OUT_XH);
  endtask

  always @(posedge clk) begin
    if (res_stb === 1'b1) begin
      if (notes.size() == 0) begin
        fail("result without a pending expectation");
      end else begin
        note = notes.pop_front();
        if (res_val[8] !== note[8]) fail("result kind out of order");
        else if (note[8]) compare_ack(res_val[0], note[0]);
        else compare_byte(res_val[7:0], note[7:0]);
      end
    end
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fail("run did not finish in time");
    complete_run();
  end

  initial begin
    err_count = 0;
    samples_checked = 0;
    {rst_n, sample_stb, ff_ev, orient_ev, wake_ev, sleep_req} = 6'h00;
    raw = '0;
    clk_en = 1'b1;
    trim_valid = 1'b0;
    trim = 48'({$random(seed), $random(seed)});
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    compare_pin(afe_en, 1'b0, "analog enable");
    compare_pin(clk_run, 1'b0, "clock run");
    repeat (9) pend.push_back(8'h00);
    rd(REG_RUN_CTRL);
    // writes: read-only places and the reserved range code are refused, range code 1 is taken
    wr(REG_OUT_XH, 8'h5A);
    wr(REG_MODE, 8'h02);
    wr(REG_RANGE, 8'h01);
    wr(REG_RANGE, 8'h03);
    pend.push_back(8'h00);
    rd(REG_OUT_XH);
    pend.push_back(8'h01);
    rd(REG_RANGE);
    pend.push_back(8'h00);
    rd(REG_MODE);
    pend.push_back(8'h00);
    rd(8'h20);
    notes.push_back(9'h101);
    host.probe(DEV_ADDR ^ 7'h01);
    sleep_req = 1'b1;
    step(3);
    compare_pin(sleep, 1'b0, "sleep in standby");
    wr(REG_RUN_CTRL, 8'h01);
    compare_pin(afe_en, 1'b1, "analog enable");
    compare_pin(clk_run, 1'b1, "clock run");
    compare_pin(sleep, 1'b1, "sleep while active");
    pend.push_back(8'h02);
    rd(REG_MODE);
    sleep_req = 1'b0;
    step(3);
    compare_pin(sleep, 1'b0, "sleep after request drop");
    pend.push_back(8'h01);
    rd(REG_MODE);
    // trim store not valid yet: an active sample strobe must not be taken
    sample_stb = 1'b1;
    step(1);
    sample_stb = 1'b0;
    pend.push_back(8'h00);
    rd(REG_STATUS);
    trim_valid = 1'b1;
    for (int o = 0; o < 4; o++) begin
      wr(REG_MEAS_CTRL, {o[0], 5'h00, o[1:0]});
      compare_byte({6'h00, osr}, 8'(o));
      compare_pin(self_test, o[0], "self-test output");
    end
    for (int r = 0; r < 3; r++) begin
      for (int a = 0; a < 3; a++) begin
        uoff[a] = 8'($random(seed));
        wr(REG_UOFF_X + 8'(a), uoff[a]);
      end
      wr(REG_RANGE, 8'(r));
      wr(REG_MEAS_CTRL, 8'h00);
      sample_check(1'b0, r);
      wr(REG_MEAS_CTRL, 8'h80);
      sample_check(1'b1, r);
    end
    // fast read skips the low halves: upper bytes of x, y, z, then status
    wr(REG_RUN_CTRL, 8'h03);
    for (int a = 0; a < 3; a++) pend.push_back(msb[a]);
    pend.push_back(8'h01);
    rd(REG_OUT_XH);
    // going through standby clears samples and flags but keeps settings
    wr(REG_RUN_CTRL, 8'h00);
    compare_pin(afe_en, 1'b0, "analog enable");
    wr(REG_RUN_CTRL, 8'h01);
    repeat (7) pend.push_back(8'h00);
    pend.push_back(8'h01);
    pend.push_back(8'h80);
    pend.push_back(8'h02);
    repeat (2) pend.push_back(8'h00);
    for (int a = 0; a < 3; a++) pend.push_back(uoff[a]);
    rd(REG_OUT_XH);
    for (int s = 0; s < 4; s++) begin
      wr(REG_EV_EN, 8'h01 << s);
      wr(REG_EV_ROUTE, s[0] ? 8'h01 << s : 8'h00);
      {wake_ev, orient_ev, ff_ev, sample_stb} = 4'h1 << s;
      step(1);
      {wake_ev, orient_ev, ff_ev, sample_stb} = 4'h0;
      step(3);
      compare_pin(line_one, s[0], "event line one");
      compare_pin(line_two, !s[0], "event line two");
      pend.push_back(8'h01 << s);
      rd(REG_STATUS);
      compare_pin(line_one | line_two, 1'b0, "event lines after clear");
    end
    // clock enable low freezes everything: strobes in that time are lost
    clk_en = 1'b0;
    {ff_ev, sample_stb} = 2'h3;
    step(2);
    {ff_ev, sample_stb} = 2'h0;
    clk_en = 1'b1;
    pend.push_back(8'h00);
    rd(REG_STATUS);
    step(4);
    if (notes.size() != 0) fail("expected results never appeared");
    complete_run();
  end
endmodule
